// ==== pkg/mne_regs.svh ====
// Register offsets, opcodes, field positions and reset values
// Assumes inclusion by the slice top module and its package users
`ifndef MNE_REGS_SVH
`define MNE_REGS_SVH

// ==========================================
// Register offsets (byte addresses)
`define MNE_OFS_INSTR   8'h00
`define MNE_OFS_WORK    8'h04
`define MNE_OFS_BANK    8'h08
`define MNE_OFS_PROD    8'h0C
`define MNE_OFS_STAT    8'h10
`define MNE_OFS_CTRL    8'h14
`define MNE_OFS_INDEX   8'h18

// ==========================================
// Fields
`define MNE_BUSY_BIT    16
`define MNE_EXT_BIT     0
`define MNE_ACC_BIT     8

// ==========================================
// Opcodes
`define MNE_OP_MLIT     8'h0D
`define MNE_OP_MFILE    7'h01
`define MNE_OP_NEG      7'h36
`define MNE_OP_NOOP_HI  4'hF
`define MNE_IDX_MAX     8'h5F
`define MNE_ACC_HI_BANK 4'hF

// ==========================================
// Reset values
`define MNE_WORK_RST    8'h00
`define MNE_BANK_RST    8'h00
`define MNE_PROD_RST    16'h0000
`define MNE_STAT_RST    5'h00
`define MNE_INDEX_RST   12'h000

`endif

// ==== pkg/mne_pkg.sv ====
// Types shared by the execution slice and its bench
// Assumes mne_regs.svh on the include path
`default_nettype none
package mne_pkg;
  `include "mne_regs.svh"

  typedef enum logic [2:0] {
    MNE_IDLE = 3'b000,
    MNE_Q1   = 3'b001,
    MNE_Q2   = 3'b010,
    MNE_Q3   = 3'b011,
    MNE_Q4   = 3'b100
  } mne_phase_t;

  typedef enum logic [1:0] {
    MNE_NOOP  = 2'b00,
    MNE_MLIT  = 2'b01,
    MNE_MFILE = 2'b10,
    MNE_NEG   = 2'b11
  } mne_op_t;

  // Status register order: negative, overflow, zero, digit carry, carry
  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } mne_flags_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } mne_dm_t;

  // Anything outside this slice decodes as no operation
  function automatic mne_op_t mne_decode(input logic [15:0] iw);
    if (iw[15:8] == `MNE_OP_MLIT) return MNE_MLIT;
    if (iw[15:9] == `MNE_OP_MFILE) return MNE_MFILE;
    if (iw[15:9] == `MNE_OP_NEG) return MNE_NEG;
    return MNE_NOOP;
  endfunction : mne_decode
endpackage : mne_pkg
`default_nettype wire

// ==== rtl/mne_alu.sv ====
// Product and negate arithmetic of the slice
// Assumes registered operands from the slice top
`timescale 1ns/100ps
`default_nettype none
module mne_alu (
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       b,
  output var  logic [15:0]      prod,
  output var  logic [7:0]       neg,
  output var  mne_pkg::mne_flags_t nflags
);
  import mne_pkg::*;
  logic [8:0] sum9;
  logic [4:0] sum5;

  always_comb begin
    prod                    = 16'(a) * 16'(b);
    sum9                    = {1'b0, ~b} + 9'h001;
    sum5                    = {1'b0, ~b[3:0]} + 5'h01;
    neg                     = sum9[7:0];
    nflags.n                = sum9[7];
    nflags.overflow_flag    = (b == 8'h80);
    nflags.z                = (sum9[7:0] == 8'h00);
    nflags.digit_carry_flag = sum5[4];
    nflags.c                = sum9[8];
  end
endmodule : mne_alu
`default_nettype wire

// ==== rtl/mne_slice.sv ====
// Multiply and negate execution slice with AHB-Lite register access
// Assumes a data memory that answers dm_rdata while dm.re is high
// Function
// - Literal multiply uses low instruction byte
// - Product high and low bytes to pair
// - File multiply leaves W and source alone
// - Multiplies never touch any status flag
// - File multiply reads operand at file address
// - Access bit picks access or selected bank
// - Extended set indexes low access addresses
// - Negate writes two's complement back in place
// - Negate updates all five arithmetic flags
// - One word, four quarters, read Q2 write Q4
// - Bank select upper nibble always zero
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "mne_regs.svh"
module mne_slice (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  mne_pkg::mne_dm_t dm,
  input  wire logic [7:0]  dm_rdata
);
  import mne_pkg::*;

  logic [7:0]  w_reg, bank_sel_reg, product_high_reg, product_low_reg;
  logic [7:0]  opnd_reg, wop_reg, wa_reg;
  logic [15:0] instr_reg;
  logic [11:0] fsr2_reg;
  logic [31:0] hrdata_reg, rd_val;
  logic        ext_reg, wr_pend_reg, hreadyout_reg, hresp_reg;
  mne_flags_t  stat_reg, nflags;
  mne_phase_t  ph_reg;
  mne_op_t     op_reg;
  mne_dm_t     dm_reg;
  logic [15:0] prod;
  logic [7:0]  neg;
  logic        addr_ph, start, stat_wr, prod_wr, bank_wr;

  // ==========================================
  // Effective file address
  function automatic logic [11:0] eff_addr(input logic [15:0] iw, input logic [7:0] bank,
                                           input logic ext, input logic [11:0] base);
    if (iw[`MNE_ACC_BIT]) return {bank[3:0], iw[7:0]};
    if (ext && iw[7:0] <= `MNE_IDX_MAX) return base + {4'h0, iw[7:0]};
    if (iw[7:0] <= `MNE_IDX_MAX) return {4'h0, iw[7:0]};
    return {`MNE_ACC_HI_BANK, iw[7:0]};
  endfunction : eff_addr

  // ==========================================
  // AHB-Lite slave, zero wait states
  assign addr_ph = hsel & hready & htrans[1];
  assign start   = wr_pend_reg && wa_reg == `MNE_OFS_INSTR && ph_reg == MNE_IDLE;
  assign stat_wr = wr_pend_reg && wa_reg == `MNE_OFS_STAT;
  assign prod_wr = wr_pend_reg && wa_reg == `MNE_OFS_PROD;
  assign bank_wr = wr_pend_reg && wa_reg == `MNE_OFS_BANK;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_reg   <= 1'b0;
      wa_reg        <= 8'h00;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      wr_pend_reg   <= addr_ph & hwrite;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      if (addr_ph) begin
        wa_reg <= haddr[7:0];
      end
    end
  end

  always_comb begin
    unique case (haddr[7:0])
      `MNE_OFS_INSTR: rd_val = {15'h0000, ph_reg != MNE_IDLE, instr_reg};
      `MNE_OFS_WORK:  rd_val = {24'h000000, w_reg};
      `MNE_OFS_BANK:  rd_val = {24'h000000, bank_sel_reg};
      `MNE_OFS_PROD:  rd_val = {16'h0000, product_high_reg, product_low_reg};
      `MNE_OFS_STAT:  rd_val = {27'h0000000, stat_reg};
      `MNE_OFS_CTRL:  rd_val = {31'h00000000, ext_reg};
      `MNE_OFS_INDEX: rd_val = {20'h00000, fsr2_reg};
      default:        rd_val = 32'h00000000;
    endcase
  end

  // Captured in the address phase; a read right after a write sees old data
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata_reg <= 32'h00000000;
    end else if (addr_ph && !hwrite) begin
      hrdata_reg <= rd_val;
    end
  end

  // ==========================================
  // Software-owned registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      w_reg        <= `MNE_WORK_RST;
      bank_sel_reg <= `MNE_BANK_RST;
      ext_reg      <= 1'b0;
      fsr2_reg     <= `MNE_INDEX_RST;
    end else if (wr_pend_reg) begin
      unique case (wa_reg)
        `MNE_OFS_WORK:  w_reg        <= hwdata[7:0];
        `MNE_OFS_BANK:  bank_sel_reg <= {4'h0, hwdata[3:0]};
        `MNE_OFS_CTRL:  ext_reg      <= hwdata[`MNE_EXT_BIT];
        `MNE_OFS_INDEX: fsr2_reg     <= hwdata[11:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Quarter sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ph_reg    <= MNE_IDLE;
      op_reg    <= MNE_NOOP;
      instr_reg <= 16'h0000;
    end else begin
      unique case (ph_reg)
        MNE_IDLE: begin
          if (start) begin
            ph_reg    <= MNE_Q1;
            instr_reg <= hwdata[15:0];
            op_reg    <= mne_decode(hwdata[15:0]);
          end
        end
        MNE_Q1:  ph_reg <= MNE_Q2;
        MNE_Q2:  ph_reg <= MNE_Q3;
        MNE_Q3:  ph_reg <= MNE_Q4;
        MNE_Q4:  ph_reg <= MNE_IDLE;
        default: ph_reg <= MNE_IDLE;
      endcase
    end
  end

  // ==========================================
  // Data memory access and operands
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dm_reg   <= '0;
      opnd_reg <= 8'h00;
      wop_reg  <= 8'h00;
    end else begin
      unique case (ph_reg)
        MNE_Q1: begin
          dm_reg.addr <= eff_addr(instr_reg, bank_sel_reg, ext_reg, fsr2_reg);
          dm_reg.re   <= op_reg == MNE_MFILE || op_reg == MNE_NEG;
        end
        MNE_Q2: begin
          dm_reg.re <= 1'b0;
          wop_reg   <= w_reg;
          opnd_reg  <= (op_reg == MNE_MLIT) ? instr_reg[7:0] : dm_rdata;
        end
        MNE_Q3: begin
          // Only negate writes memory; the multiply source stays intact
          if (op_reg == MNE_NEG) begin
            dm_reg.we    <= 1'b1;
            dm_reg.wdata <= neg;
          end
        end
        MNE_Q4:  dm_reg.we <= 1'b0;
        default: ;
      endcase
    end
  end

  mne_alu u_alu (
    .a      (wop_reg),
    .b      (opnd_reg),
    .prod   (prod),
    .neg    (neg),
    .nflags (nflags)
  );

  // ==========================================
  // Product pair and status; hardware wins over a bus write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {product_high_reg, product_low_reg} <= `MNE_PROD_RST;
    end else if (ph_reg == MNE_Q4 && (op_reg == MNE_MLIT || op_reg == MNE_MFILE)) begin
      product_high_reg <= prod[15:8];
      product_low_reg  <= prod[7:0];
    end else if (prod_wr) begin
      {product_high_reg, product_low_reg} <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stat_reg <= `MNE_STAT_RST;
    end else if (ph_reg == MNE_Q4 && op_reg == MNE_NEG) begin
      stat_reg <= nflags;
    end else if (stat_wr) begin
      stat_reg <= hwdata[4:0];
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign dm        = dm_reg;

  // ==========================================
  // Assertions
  sequence s_quarters;
    ph_reg == MNE_Q1 ##1 ph_reg == MNE_Q2 ##1 ph_reg == MNE_Q3 ##1 ph_reg == MNE_Q4
      ##1 ph_reg == MNE_IDLE;
  endsequence

  sequence s_neg_read;
    ph_reg == MNE_Q2 && op_reg == MNE_NEG;
  endsequence

  property p_cycle;
    @(posedge clk) disable iff (!rstn) start |=> s_quarters;
  endproperty
  a_cycle: assert property (p_cycle) else $error("instruction not four quarters");

  property p_mlit;
    @(posedge clk) disable iff (!rstn)
      (ph_reg == MNE_Q2 && op_reg == MNE_MLIT) |-> ##3
        {product_high_reg, product_low_reg} == 16'($past(w_reg, 3)) * 16'($past(instr_reg[7:0], 3));
  endproperty
  a_mlit: assert property (p_mlit) else $error("literal product wrong");

  property p_mfile;
    @(posedge clk) disable iff (!rstn)
      (ph_reg == MNE_Q2 && op_reg == MNE_MFILE) |-> ##3
        product_high_reg == 8'(({8'h00, $past(w_reg, 3)} * {8'h00, $past(dm_rdata, 3)}) >> 8) &&
        product_low_reg == 8'($past(w_reg, 3) * $past(dm_rdata, 3));
  endproperty
  a_mfile: assert property (p_mfile) else $error("file product or byte split wrong");

  property p_keep;
    @(posedge clk) disable iff (!rstn)
      (ph_reg != MNE_IDLE && op_reg != MNE_NEG) |-> !dm_reg.we;
  endproperty
  a_keep: assert property (p_keep) else $error("memory written outside negate");

  property p_noflag;
    @(posedge clk) disable iff (!rstn)
      (ph_reg == MNE_Q4 && op_reg inside {MNE_MLIT, MNE_MFILE, MNE_NOOP} && !stat_wr)
        |=> $stable(stat_reg);
  endproperty
  a_noflag: assert property (p_noflag) else $error("status changed by multiply");

  property p_bank;
    @(posedge clk) disable iff (!rstn)
      (ph_reg == MNE_Q1 && instr_reg[8]) |=>
        dm_reg.addr == {$past(bank_sel_reg[3:0]), $past(instr_reg[7:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_index;
    @(posedge clk) disable iff (!rstn)
      (ph_reg == MNE_Q1 && !instr_reg[8] && ext_reg && instr_reg[7:0] <= `MNE_IDX_MAX) |=>
        dm_reg.addr == $past(fsr2_reg) + {4'h0, $past(instr_reg[7:0])};
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_neg;
    @(posedge clk) disable iff (!rstn)
      s_neg_read |=> ##1 dm_reg.we && dm_reg.wdata == 8'(~$past(dm_rdata, 2) + 8'h01)
        && $stable(dm_reg.addr);
  endproperty
  a_neg: assert property (p_neg) else $error("negate result wrong");

  property p_negflag;
    @(posedge clk) disable iff (!rstn)
      (ph_reg == MNE_Q4 && op_reg == MNE_NEG) |=>
        stat_reg.z == ($past(dm_reg.wdata) == 8'h00) && stat_reg.c == stat_reg.z &&
        stat_reg.n == $past(dm_reg.wdata[7]) &&
        stat_reg.overflow_flag == ($past(dm_reg.wdata) == 8'h80) &&
        stat_reg.digit_carry_flag == ($past(dm_reg.wdata[3:0]) == 4'h0);
  endproperty
  a_negflag: assert property (p_negflag) else $error("negate flags wrong");

  property p_bank_sel;
    @(posedge clk) disable iff (!rstn) bank_wr |=> bank_sel_reg == {4'h0, $past(hwdata[3:0])};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select upper nibble set");

  property p_noop;
    @(posedge clk) disable iff (!rstn)
      (ph_reg == MNE_Q4 && op_reg == MNE_NOOP && !prod_wr) |=>
        $stable({product_high_reg, product_low_reg}) && !dm_reg.we && !dm_reg.re;
  endproperty
  a_noop: assert property (p_noop) else $error("no operation changed state");

  // Memory strobes only in their own quarter
  property p_quarter_io;
    @(posedge clk) disable iff (!rstn)
      (dm_reg.re || dm_reg.we) |-> ph_reg == (dm_reg.we ? MNE_Q4 : MNE_Q2);
  endproperty
  a_quarter_io: assert property (p_quarter_io) else $error("memory strobe in wrong quarter");
endmodule : mne_slice
`default_nettype wire

// ==== test/mne_dmem.sv ====
// Data memory model on the far side of the slice's data-memory port
// Assumes dm_rdata is sampled at the end of the cycle in which dm.re is high
`timescale 1ns/100ps
`default_nettype none
module mne_dmem (
  input  wire logic             clk,
  input  wire mne_pkg::mne_dm_t dm,
  output logic [7:0]            dm_rdata
);
  import mne_pkg::*;
  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
  // ==========================================
  // Off-cycle data is inverted so a late sample cannot pass
  assign dm_rdata = dm.re ? mem[dm.addr] : ~last;
  always @(posedge clk) begin
    if (dm.re) last <= mem[dm.addr];
    if (dm.we) mem[dm.addr] <= dm.wdata;
  end
endmodule : mne_dmem
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the multiply and negate slice
// Assumes the slice answers AHB-Lite with zero wait states
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mne_pkg::*;
  logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, seed = 32'h18, q;
  logic [1:0]  htrans = '0;
  logic        hreadyout, hresp;
  mne_dm_t     dm;
  logic [7:0]  dm_rdata, v, res;
  int          num_errors = 0, n_compared = 0;
  int          w_m, bk_m, st_m, ext_m, bs_m, p_m, a, f, ad, md;
  always #5 clk = ~clk;
  mne_slice i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dm(dm), .dm_rdata(dm_rdata));
  mne_dmem i_mem (.clk(clk), .dm(dm), .dm_rdata(dm_rdata));
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] ad8, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    haddr <= {24'h0, ad8};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 50);
    chk({31'h0, hreadyout}, 32'h1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 50);
    chk({31'h0, hreadyout}, 32'h1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  function automatic int fa(int ab, int fv);
    if (ab != 0) return bk_m * 256 + fv;
    if (ext_m != 0 && fv <= 'h5F) return (bs_m + fv) % 4096;
    return (fv <= 'h5F) ? fv : 'hF00 + fv;
  endfunction : fa
  task automatic chkall();
    bus(0, 8'h04, 0); chk(q, w_m);
    bus(0, 8'h08, 0); chk(q, bk_m);
    bus(0, 8'h0C, 0); chk(q, p_m);
    bus(0, 8'h10, 0); chk(q, st_m);
    bus(0, 8'h14, 0); chk(q, ext_m);
    bus(0, 8'h18, 0); chk(q, bs_m);
  endtask : chkall
  task automatic exec(input logic [15:0] iw);
    int n;
    n = 0;
    bus(1, 8'h00, {16'h0, iw});
    do begin
      bus(0, 8'h00, 0);
      n++;
    end while (q[16] !== 1'b0 && n < 20);
    chk({31'h0, n >= 2 && n <= 3}, 1);
    chk(q, {16'h0, iw});
  endtask : exec
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // ==========================================
  // Main sequence
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  initial begin
    w_m = 0; bk_m = 0; st_m = 0; ext_m = 0; bs_m = 0; p_m = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chkall();
    bus(0, 8'h1C, 0); chk(q, 0);
    bus(1, 8'h1C, 32'hFFFFFFFF); bus(0, 8'h1C, 0); chk(q, 0);
    bus(1, 8'h08, 32'hFF); bk_m = 15;
    chkall();
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      r_lit(i);
    end
    $display("test literal multiply done");
    for (int i = 0; i < 16; i++) begin
      md = i % 4;
      a = (md == 0);
      ext_m = (md == 3) || (md != 1 && i % 8 >= 4);
      f = rnd() % 256;
      if (md == 1 || md == 3) f = f % 96;
      if (md == 2) f = 96 + f % 160;
      bs_m = rnd() % 4096;
      bk_m = rnd() % 16;
      w_m = rnd() % 256;
      v = (i == 8) ? 8'h00 : (i == 9) ? 8'h80 : (i == 10) ? 8'h10 : rnd();
      bus(1, 8'h14, ext_m); bus(1, 8'h18, bs_m); bus(1, 8'h08, bk_m); bus(1, 8'h04, w_m);
      ad = fa(a, f);
      i_mem.mem[ad] = v;
      if (i < 8) begin
        exec({7'h01, a[0], f[7:0]});
        p_m = w_m * v;
        chk(i_mem.mem[ad], v);
      end else begin
        exec({7'h36, a[0], f[7:0]});
        res = ~v + 8'h01;
        st_m = {res[7], v == 8'h80, res == 0, v[3:0] == 0, v == 0};
        chk(i_mem.mem[ad], res);
      end
      chkall();
    end
    $display("test file multiply and negate done");
    exec(16'h0000);
    exec(16'hF123);
    chkall();
    $display("test no operation done");
    test_done();
  end
  task automatic r_lit(input int i);
    logic [7:0] k;
    k = rnd();
    w_m = (i == 0) ? 0 : rnd() % 256;
    st_m = rnd() % 32;
    bus(1, 8'h04, w_m); bus(1, 8'h10, st_m);
    exec({8'h0D, k});
    p_m = w_m * k;
    chkall();
  endtask : r_lit
endmodule : tb_top
`default_nettype wire
